// ---- design/gair_debounce.sv ----
// Purpose: Synchronise and debounce one pin, with edge pulses
// Assumes: Pin is asynchronous to clock
// Notes:   Stable output changes only after the input held for len cycles
`timescale 1ns/1ps
`default_nettype none
module gair_debounce #(
  parameter int unsigned CW = 20
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // Pin and settling length
  input  wire logic          pin,
  input  wire logic [CW-1:0] len,
  // Clean outputs
  output logic               raw_q,
  output logic               level_q,
  output logic               rise_q,
  output logic               fall_q
);
  // Refuse a counter too narrow to hold any settling length
  if (CW < 2) $error("CW too small");
  logic          s1_q;   // First sync stage, read only by raw_q
  logic [CW-1:0] cnt_q;  // Settling counter

  // Two-stage synchroniser
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      s1_q  <= 1'b0;
      raw_q <= 1'b0;
    end
    else
    begin
      s1_q  <= pin;
      raw_q <= s1_q;
    end
  end

  // Settle counter and clean level with one-shot edges
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      cnt_q   <= '0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end
    else
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (raw_q == level_q)
        cnt_q <= '0;
      else if (cnt_q + 1'b1 >= len)
      begin
        cnt_q   <= '0;
        level_q <= raw_q;
        rise_q  <= raw_q;
        fall_q  <= ~raw_q;
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- design/gair_pkg.sv ----
// Purpose: Shared constants for the GPIO alternate input router
// Assumes: 20 MHz device clock
// Notes:   APB register map and pin function codes
package gair_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 20_000_000;
  // Debounce times in microseconds, power pin extra times in milliseconds
  localparam int unsigned DBT0_US = 64;
  localparam int unsigned DBT1_US = 500;
  localparam int unsigned DBT2_US = 1000;
  localparam int unsigned DBT3_US = 4000;
  localparam int unsigned PWRON_EXTRA_MS = 40;
  localparam int unsigned PWROFF_EXTRA_MS = 5;
  localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
  localparam int unsigned MS_CYC = CLK_HZ / 1_000;
  // Pin count and function code width
  localparam int unsigned NPINS = 13;
  localparam int unsigned FNW = 5;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_POL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PINS = 8'h0c;
  localparam logic [7:0] OFF_FN0 = 8'h10;
  localparam logic [7:0] OFF_FN1 = 8'h14;
  localparam logic [7:0] OFF_FN2 = 8'h18;
  // Control register bit positions
  localparam int unsigned B_ADCFR = 0;
  localparam int unsigned B_ADCBC = 1;
  localparam int unsigned B_SPI = 2;
  localparam int unsigned B_FRST = 3;
  localparam int unsigned B_SLPEDGE = 4;
  localparam int unsigned B_SINKA_FL = 5;
  localparam int unsigned B_SINKA_PIN = 6;
  localparam int unsigned B_SINKB_FL = 7;
  localparam int unsigned B_SINKB_PIN = 8;
  localparam int unsigned B_MASKCONV = 9;
  localparam int unsigned B_DBT = 10;
  localparam int unsigned B_STARTUP = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] POL_RST = 32'h0000_1fff;
  // Function codes per input
  localparam logic [FNW-1:0] FN_NONE = 5'h00;
  localparam logic [FNW-1:0] FN_FULLRST = 5'h01;
  localparam logic [FNW-1:0] FN_FLASH = 5'h02;
  localparam logic [FNW-1:0] FN_SLEEP = 5'h03;
  localparam logic [FNW-1:0] FN_KICK = 5'h04;
  localparam logic [FNW-1:0] FN_REGEN = 5'h05;
  localparam logic [FNW-1:0] FN_LPA = 5'h06;
  localparam logic [FNW-1:0] FN_LPB = 5'h07;
  localparam logic [FNW-1:0] FN_LPC = 5'h08;
  localparam logic [FNW-1:0] FN_MASK = 5'h09;
  localparam logic [FNW-1:0] FN_MR = 5'h0a;
  localparam logic [FNW-1:0] FN_PWROFF = 5'h0b;
  localparam logic [FNW-1:0] FN_PWRON = 5'h0c;
  localparam logic [FNW-1:0] FN_WAKE = 5'h0d;
  localparam logic [FNW-1:0] FN_CSN = 5'h0e;
  // Pin numbers used by fixed routes
  localparam int unsigned PIN_FRAME = 5;
  localparam int unsigned PIN_BIT_A = 6;
  localparam int unsigned PIN_PORTSEL = 7;
  localparam int unsigned PIN_BIT_B = 8;
endpackage

// ---- design/gair_router.sv ----
// Purpose: Route and decode alternate input functions of the GPIO pins
// Assumes: APB slave, zero wait states; pins asynchronous
// Notes:   Outputs are registered; each pin is synced and debounced
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Frame clock alt from pin 5
// - Bit clock alt from pin 6 or 8
// - Full reset input restarts with current config
// - Control port mode forces pin 7 select
// - Flash starts on rising pin edge only
// - Flash needs flash mode and pin source
// - Level sleep held while pin asserted
// - Edge sleep on active edge
// - Edge sleep lasts until startup event
// - Watchdog kicked on rising edge only
// - Regulator enable input drives regulator one
// - Low power requests drive their groups
// - Mask input blocks or starts conversions
// - Manual reset drives reset outputs low
// - Manual reset touches nothing else internal
// - Shutdown request starts controlled shutdown
// - Power up and wake debounce plus 40ms
// - Shutdown debounce plus 5ms
// - Config bit selects active low polarity for full reset, sleep, regulator enable, manual reset and wake
module gair_router #(
  parameter int unsigned NP = gair_pkg::NPINS
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // GPIO pins
  input  wire logic [NP-1:0] gpio_in,
  // Audio clock routing
  output logic               adc_frame_clock_alt,
  output logic               adc_bit_clock_alt,
  output logic               adc_frame_use_alt,
  output logic               adc_bit_use_alt,
  // Control port select
  output logic               control_port_select_n,
  // Functional requests
  output logic               full_reset_req,
  output logic               flash_start_sink_a,
  output logic               flash_start_sink_b,
  output logic               sleep_req,
  output logic               watchdog_kick,
  output logic               regulator1_enable,
  output logic               low_power_req_a,
  output logic               low_power_req_b,
  output logic               low_power_req_c,
  output logic               adc_block_all,
  output logic               adc_start_conv,
  output logic               system_reset_out_n,
  output logic               memory_reset_out_n,
  output logic               shutdown_req,
  output logic               power_up_req,
  output logic               wake_req
);
  // Refuse a pin count other than the fixed register map
  if (NP != gair_pkg::NPINS)
    $error("NP must equal the pin count");

  localparam int unsigned CW = 20;
  // Base debounce lengths and power pin extras in cycles
  localparam logic [CW-1:0] DB0 = CW'(gair_pkg::DBT0_US * gair_pkg::US_CYC);
  localparam logic [CW-1:0] DB1 = CW'(gair_pkg::DBT1_US * gair_pkg::US_CYC);
  localparam logic [CW-1:0] DB2 = CW'(gair_pkg::DBT2_US * gair_pkg::US_CYC);
  localparam logic [CW-1:0] DB3 = CW'(gair_pkg::DBT3_US * gair_pkg::US_CYC);
  localparam logic [CW-1:0] XON = CW'(gair_pkg::PWRON_EXTRA_MS * gair_pkg::MS_CYC);
  localparam logic [CW-1:0] XOFF = CW'(gair_pkg::PWROFF_EXTRA_MS * gair_pkg::MS_CYC);

  logic [31:0]          ctrl_q;     // Control register
  logic [31:0]          pol_q;      // Pin config bits (1 = active low)
  logic [NP*gair_pkg::FNW-1:0] fn_q; // Function select per pin
  logic [NP-1:0]        raw, lvl, rise, fall;
  logic                 act_rise [NP];
  logic                 act_lvl [NP];
  logic [1:0]           dbt;
  logic [CW-1:0]        base_len;
  logic                 sleep_edge_q; // Latched edge sleep

  // Function field of one pin
  function automatic logic [gair_pkg::FNW-1:0] fn_of(input int unsigned p);
    fn_of = fn_q[p*gair_pkg::FNW +: gair_pkg::FNW];
  endfunction

  // Base debounce from global time select
  assign dbt = ctrl_q[gair_pkg::B_DBT +: 2];
  always_comb
  begin
    unique case (dbt)
      2'h0: base_len = DB0;
      2'h1: base_len = DB1;
      2'h2: base_len = DB2;
      2'h3: base_len = DB3;
    endcase
  end

  // Per pin sync and debounce; long times for power pins
  for (genvar g = 0; g < NP; g++)
  begin : g_pin
    logic [CW-1:0] len;
    logic [gair_pkg::FNW-1:0] f;
    logic inv;
    assign f = fn_q[g*gair_pkg::FNW +: gair_pkg::FNW];
    assign len = (f == gair_pkg::FN_PWRON || f == gair_pkg::FN_WAKE) ?
                 CW'(base_len + XON) :
                 (f == gair_pkg::FN_PWROFF) ? CW'(base_len + XOFF) :
                 base_len;
    gair_debounce #(.CW(CW)) u_db (
      .clock   (clock),
      .resetn  (resetn),
      .pin     (gpio_in[g]),
      .len     (len),
      .raw_q   (raw[g]),
      .level_q (lvl[g]),
      .rise_q  (rise[g]),
      .fall_q  (fall[g])
    );
    assign inv = pol_q[g];
    // Active level and active edge after polarity
    assign act_lvl[g]  = lvl[g] ^ inv;
    assign act_rise[g] = inv ? fall[g] : rise[g];
  end

  // Combinational decode of pin functions
  logic frst, fl, slp_l, slp_e, kick, regen, lpa, lpb, lpc, msk, mr, poff, pon, wk;
  always_comb
  begin
    frst = 1'b0; fl = 1'b0; slp_l = 1'b0; slp_e = 1'b0; kick = 1'b0;
    regen = 1'b0; lpa = 1'b0; lpb = 1'b0; lpc = 1'b0; msk = 1'b0;
    mr = 1'b0; poff = 1'b0; pon = 1'b0; wk = 1'b0;
    for (int unsigned p = 0; p < NP; p++)
    begin
      // Pin 7 is taken by the control port in serial mode
      if (!(p == gair_pkg::PIN_PORTSEL && ctrl_q[gair_pkg::B_SPI]))
      begin
        unique case (fn_of(p))
          gair_pkg::FN_FULLRST: frst = frst | act_lvl[p];
          gair_pkg::FN_FLASH:   fl = fl | rise[p];
          gair_pkg::FN_SLEEP:
          begin
            slp_l = slp_l | act_lvl[p];
            slp_e = slp_e | act_rise[p];
          end
          gair_pkg::FN_KICK:    kick = kick | rise[p];
          gair_pkg::FN_REGEN:   regen = regen | act_lvl[p];
          gair_pkg::FN_LPA:     lpa = lpa | lvl[p];
          gair_pkg::FN_LPB:     lpb = lpb | lvl[p];
          gair_pkg::FN_LPC:     lpc = lpc | lvl[p];
          gair_pkg::FN_MASK:    msk = msk | lvl[p];
          gair_pkg::FN_MR:      mr = mr | act_lvl[p];
          gair_pkg::FN_PWROFF:  poff = poff | lvl[p];
          gair_pkg::FN_PWRON:   pon = pon | lvl[p];
          gair_pkg::FN_WAKE:    wk = wk | act_lvl[p];
          default: ;
        endcase
      end
    end
  end

  // APB register writes
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ctrl_q <= gair_pkg::CTRL_RST;
      pol_q  <= gair_pkg::POL_RST;
      fn_q   <= '0;
    end
    else if (psel && penable && pwrite)
    begin
      unique case (paddr)
        gair_pkg::OFF_CTRL: ctrl_q <= pwdata;
        gair_pkg::OFF_POL:  pol_q <= pwdata;
        gair_pkg::OFF_FN0:  fn_q[0 +: 30] <= pwdata[29:0];
        gair_pkg::OFF_FN1:  fn_q[30 +: 30] <= pwdata[29:0];
        gair_pkg::OFF_FN2:  fn_q[60 +: NP*gair_pkg::FNW-60] <= pwdata[NP*gair_pkg::FNW-61:0];
        default: ;
      endcase
    end
  end

  // APB read data, ready and error
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        prdata <= '0;
        unique case (paddr)
          gair_pkg::OFF_CTRL:   prdata <= ctrl_q;
          gair_pkg::OFF_POL:    prdata <= {19'h0, pol_q[NP-1:0]};
          gair_pkg::OFF_STATUS: prdata <= {28'h0, shutdown_req, power_up_req,
                                           sleep_req, full_reset_req};
          gair_pkg::OFF_PINS:   prdata <= {19'h0, lvl};
          gair_pkg::OFF_FN0:    prdata <= {2'h0, fn_q[29:0]};
          gair_pkg::OFF_FN1:    prdata <= {2'h0, fn_q[59:30]};
          gair_pkg::OFF_FN2:    prdata <= {27'h0, fn_q[NP*gair_pkg::FNW-1:60]};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Edge sleep latch; startup event clears, new edge wins
  always_ff @(posedge clock)
  begin
    if (!resetn)
      sleep_edge_q <= 1'b0;
    else if (ctrl_q[gair_pkg::B_SLPEDGE] && slp_e)
      sleep_edge_q <= 1'b1;
    else if (ctrl_q[gair_pkg::B_STARTUP] || pon || wk)
      sleep_edge_q <= 1'b0;
  end

  // Registered functional outputs
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      full_reset_req     <= 1'b0;
      flash_start_sink_a <= 1'b0;
      flash_start_sink_b <= 1'b0;
      sleep_req          <= 1'b0;
      watchdog_kick      <= 1'b0;
      regulator1_enable  <= 1'b0;
      low_power_req_a    <= 1'b0;
      low_power_req_b    <= 1'b0;
      low_power_req_c    <= 1'b0;
      adc_block_all      <= 1'b0;
      adc_start_conv     <= 1'b0;
      system_reset_out_n <= 1'b1;
      memory_reset_out_n <= 1'b1;
      shutdown_req       <= 1'b0;
      power_up_req       <= 1'b0;
      wake_req           <= 1'b0;
    end
    else
    begin
      full_reset_req     <= frst && ctrl_q[gair_pkg::B_FRST];
      flash_start_sink_a <= fl && ctrl_q[gair_pkg::B_SINKA_FL]
                            && ctrl_q[gair_pkg::B_SINKA_PIN];
      flash_start_sink_b <= fl && ctrl_q[gair_pkg::B_SINKB_FL]
                            && ctrl_q[gair_pkg::B_SINKB_PIN];
      sleep_req          <= ctrl_q[gair_pkg::B_SLPEDGE] ?
                            (sleep_edge_q || (slp_e)) : slp_l;
      watchdog_kick      <= kick;
      regulator1_enable  <= regen;
      low_power_req_a    <= lpa;
      low_power_req_b    <= lpb;
      low_power_req_c    <= lpc;
      adc_block_all      <= msk && !ctrl_q[gair_pkg::B_MASKCONV];
      adc_start_conv     <= msk && ctrl_q[gair_pkg::B_MASKCONV];
      system_reset_out_n <= !mr;
      memory_reset_out_n <= !mr;
      shutdown_req       <= poff;
      power_up_req       <= pon;
      wake_req           <= wk;
    end
  end

  // Audio clock and control select routing from synced pins
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      adc_frame_clock_alt   <= 1'b0;
      adc_bit_clock_alt     <= 1'b0;
      adc_frame_use_alt     <= 1'b0;
      adc_bit_use_alt       <= 1'b0;
      control_port_select_n <= 1'b1;
    end
    else
    begin
      adc_frame_use_alt   <= ctrl_q[gair_pkg::B_ADCFR];
      adc_frame_clock_alt <= raw[gair_pkg::PIN_FRAME];
      adc_bit_use_alt     <= ctrl_q[gair_pkg::B_ADCBC];
      adc_bit_clock_alt   <= (fn_of(gair_pkg::PIN_BIT_B) == gair_pkg::FN_NONE) ?
                             raw[gair_pkg::PIN_BIT_A] : raw[gair_pkg::PIN_BIT_B];
      control_port_select_n <= ctrl_q[gair_pkg::B_SPI] ?
                               raw[gair_pkg::PIN_PORTSEL] : 1'b1;
    end
  end

  // Checks
  watchdog_edge_a: assert property (@(posedge clock) disable iff (!resetn)
    watchdog_kick |=> !watchdog_kick) else $error("kick longer than one cycle");
  flash_gate_a: assert property (@(posedge clock) disable iff (!resetn)
    flash_start_sink_a |-> $past(ctrl_q[gair_pkg::B_SINKA_FL])) else $error("flash gated off");
  mr_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(mr) |-> !memory_reset_out_n && !system_reset_out_n) else $error("reset not low");
  edge_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    sleep_edge_q && !ctrl_q[gair_pkg::B_STARTUP] && !pon && !wk |=> sleep_edge_q)
    else $error("edge sleep dropped");
  port_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    !$past(ctrl_q[gair_pkg::B_SPI]) |-> control_port_select_n) else $error("select forced");
  full_rst_a: assert property (@(posedge clock) disable iff (!resetn)
    full_reset_req |-> $past(ctrl_q[gair_pkg::B_FRST])) else $error("reset not enabled");
  adc_mode_a: assert property (@(posedge clock) disable iff (!resetn)
    !(adc_block_all && adc_start_conv)) else $error("mask both modes");
  apb_ready_a: assert property (@(posedge clock) disable iff (!resetn)
    psel && !penable |=> pready) else $error("no ready");
  // Routing and level-follow checks, one cycle behind their sources
  port_spi_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(ctrl_q[gair_pkg::B_SPI]) |-> control_port_select_n == $past(raw[gair_pkg::PIN_PORTSEL]))
    else $error("select not routed");
  sleep_level_a: assert property (@(posedge clock) disable iff (!resetn)
    !$past(ctrl_q[gair_pkg::B_SLPEDGE]) |-> sleep_req == $past(slp_l)) else $error("sleep level");
  frame_route_a: assert property (@(posedge clock) disable iff (!resetn)
    adc_frame_clock_alt == $past(raw[gair_pkg::PIN_FRAME])) else $error("frame clock route");
  regen_follow_a: assert property (@(posedge clock) disable iff (!resetn)
    regulator1_enable == $past(regen)) else $error("regulator enable");
  low_power_a: assert property (@(posedge clock) disable iff (!resetn)
    low_power_req_a == $past(lpa)) else $error("low power request");
  cover_spi: cover property (@(posedge clock) !control_port_select_n);
  cover_kick: cover property (@(posedge clock) watchdog_kick);
  cover_sleep: cover property (@(posedge clock) sleep_edge_q);
  cover_flash: cover property (@(posedge clock) flash_start_sink_b);
endmodule
`default_nettype wire

// ---- tb/gair_pin_model.sv ----
// Purpose: Pin-side model of the host processor and external switches
// Assumes: Pins change only just after a rising clock edge
// Notes:   Optional contact chatter before a new level settles
`timescale 1ns/1ps
`default_nettype none
module gair_pin_model (
  // Clock
  input  wire logic        clock,
  // Requested levels and chatter enable
  input  wire logic [12:0] target,
  input  wire logic        bounce,
  // Pin levels seen by the router
  output logic      [12:0] pins
);
  logic [12:0] old_q  = 13'h0000; // Level before the latest request
  logic [12:0] goal_q = 13'h0000; // Latest requested level
  logic [2:0]  cnt_q  = 3'h0;     // Chatter cycles left
  initial pins = 13'h0000;
  // Host levels settle after short chatter between old and new level
  always @(posedge clock)
  begin
    if (target !== goal_q)
    begin
      old_q  <= goal_q;
      goal_q <= target;
      cnt_q  <= bounce ? 3'h5 : 3'h0;
    end
    else if (cnt_q != 3'h0)
    begin
      cnt_q <= cnt_q - 3'h1;
    end
    // Only the pins that change take part in the chatter
    pins <= (cnt_q[0] && cnt_q != 3'h0) ? old_q : goal_q;
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the GPIO alternate input router
// Assumes: Shortest debounce select, power pins left unassigned
// Notes:   Model tracks pins, polarity and control, compares at each step
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Bus, pins and router outputs
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr, bounce, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, ctrl_m, pol_m, lfsr;
  logic [12:0] gpio_in, target, pins_m;
  logic        adc_frame_clock_alt, adc_bit_clock_alt, adc_frame_use_alt, adc_bit_use_alt;
  logic        control_port_select_n, full_reset_req, flash_start_sink_a, flash_start_sink_b;
  logic        sleep_req, watchdog_kick, regulator1_enable, low_power_req_a, low_power_req_b;
  logic        low_power_req_c, adc_block_all, adc_start_conv, system_reset_out_n;
  logic        memory_reset_out_n, shutdown_req, power_up_req, wake_req, sleep_m;
  // Counters of the run and of event pulses
  int num_errors = 0, comparisons = 0, seen_fa = 0, seen_fb = 0, seen_kick = 0;
  int exp_fa = 0, exp_fb = 0, exp_kick = 0;

  gair_router dut_u (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gpio_in, .adc_frame_clock_alt, .adc_bit_clock_alt, .adc_frame_use_alt, .adc_bit_use_alt,
    .control_port_select_n, .full_reset_req, .flash_start_sink_a, .flash_start_sink_b,
    .sleep_req, .watchdog_kick, .regulator1_enable, .low_power_req_a, .low_power_req_b,
    .low_power_req_c, .adc_block_all, .adc_start_conv, .system_reset_out_n,
    .memory_reset_out_n, .shutdown_req, .power_up_req, .wake_req
  );
  gair_pin_model pin_u (.clock, .target, .bounce, .pins(gpio_in));

  // Clock at 20 MHz
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Count one-cycle event pulses
  always @(posedge clock)
  begin
    if (flash_start_sink_a === 1'b1) seen_fa++;
    if (flash_start_sink_b === 1'b1) seen_fb++;
    if (watchdog_kick === 1'b1) seen_kick++;
  end

  // Pseudo-random source, several shifts per draw
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    for (int k = 0; k < 13; k++)
      v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction

  // Expected level outputs from pins, polarity and control
  function automatic logic [31:0] expect_out();
    logic [12:0] a;
    a = pins_m ^ pol_m[12:0];
    return {14'h0, pins_m[5], pins_m[6], ctrl_m[0], ctrl_m[1], ctrl_m[2] ? pins_m[7] : 1'b1,
            a[0] & ctrl_m[3], sleep_m, a[4], pins_m[9], pins_m[10], pins_m[11],
            pins_m[5] & ~ctrl_m[9], pins_m[5] & ctrl_m[9], ~a[12], ~a[12], 3'h0};
  endfunction

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge clock);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  // Write a register, update the model, read it back unless a control write sets startup
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
    chk({31'h0, err}, 32'h0);
    if (a == gair_pkg::OFF_CTRL) ctrl_m = d;
    if (a == gair_pkg::OFF_POL) pol_m = d;
    if (d[12] && a == gair_pkg::OFF_CTRL) sleep_m = 1'b0;
    else
    begin
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, d);
    end
  endtask

  // Move pins, wait for the debounced view, compare every result
  task automatic set_pins(input logic [12:0] v, input logic b);
    logic [12:0] a0, a1;
    a0 = pins_m ^ pol_m[12:0];
    a1 = v ^ pol_m[12:0];
    if (!pins_m[1] && v[1] && ctrl_m[5] && ctrl_m[6]) exp_fa++;
    if (!pins_m[1] && v[1] && ctrl_m[7] && ctrl_m[8]) exp_fb++;
    if (!pins_m[3] && v[3]) exp_kick++;
    if (ctrl_m[4] && !a0[2] && a1[2]) sleep_m = 1'b1;
    if (!ctrl_m[4]) sleep_m = a1[2];
    pins_m = v;
    @(posedge clock);
    target <= v;
    bounce <= b;
    for (int n = 0; n < 1000; n++)
    begin
      apb(1'b0, gair_pkg::OFF_PINS, 32'h0, rd, err);
      if (rd[12:0] === v)
        break;
    end
    if (rd[12:0] !== v)
    begin
      num_errors++;
      print_verdict();
    end
    repeat (4) @(posedge clock);
    chk({14'h0, adc_frame_clock_alt, adc_bit_clock_alt, adc_frame_use_alt, adc_bit_use_alt,
         control_port_select_n, full_reset_req, sleep_req, regulator1_enable, low_power_req_a,
         low_power_req_b, low_power_req_c, adc_block_all, adc_start_conv, system_reset_out_n,
         memory_reset_out_n, shutdown_req, power_up_req, wake_req}, expect_out());
    apb(1'b0, gair_pkg::OFF_STATUS, 32'h0, rd, err);
    chk(rd, {30'h0, sleep_m, a1[0] & ctrl_m[3]});
    chk(seen_fa, exp_fa);
    chk(seen_fb, exp_fb);
    chk(seen_kick, exp_kick);
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    target = 13'h0000;
    bounce = 1'b0;
    ctrl_m = gair_pkg::CTRL_RST;
    pol_m = gair_pkg::POL_RST;
    pins_m = 13'h0000;
    sleep_m = 1'b0;
    lfsr = 32'h12;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    // Reset values and a refused address
    chk({30'h0, system_reset_out_n, memory_reset_out_n}, 32'h3);
    apb(1'b0, gair_pkg::OFF_CTRL, 32'h0, rd, err);
    chk(rd, gair_pkg::CTRL_RST);
    apb(1'b0, gair_pkg::OFF_POL, 32'h0, rd, err);
    chk(rd, gair_pkg::POL_RST);
    apb(1'b0, 8'h40, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    // Assign functions to pins
    wr_reg(gair_pkg::OFF_FN0, {2'h0, gair_pkg::FN_MASK, gair_pkg::FN_REGEN, gair_pkg::FN_KICK,
                               gair_pkg::FN_SLEEP, gair_pkg::FN_FLASH, gair_pkg::FN_FULLRST});
    wr_reg(gair_pkg::OFF_FN1, {2'h0, gair_pkg::FN_LPC, gair_pkg::FN_LPB, gair_pkg::FN_LPA,
                               15'h0});
    wr_reg(gair_pkg::OFF_FN2, {27'h0, gair_pkg::FN_MR});
    set_pins(13'h0000, 1'b0);
    // Random control, polarity and pin levels, some with chatter
    for (int i = 0; i < 24; i++)
    begin
      lfsr = lfsr_next(lfsr);
      wr_reg(gair_pkg::OFF_CTRL, ({19'h0, lfsr[12:0]} & 32'h3ef) | 32'h8);
      lfsr = lfsr_next(lfsr);
      wr_reg(gair_pkg::OFF_POL, lfsr & 32'h1e35);
      lfsr = lfsr_next(lfsr);
      set_pins(lfsr[12:0], lfsr[20]);
    end
    // Edge sleep, plain and inverted, held until a startup event
    for (int p = 0; p < 2; p++)
    begin
      wr_reg(gair_pkg::OFF_CTRL, 32'h8);
      wr_reg(gair_pkg::OFF_POL, p ? 32'h4 : 32'h0);
      set_pins(p ? 13'h0004 : 13'h0000, 1'b0);
      wr_reg(gair_pkg::OFF_CTRL, 32'h18);
      set_pins(p ? 13'h0000 : 13'h0004, 1'b1);
      set_pins(p ? 13'h0004 : 13'h0000, 1'b0);
      wr_reg(gair_pkg::OFF_CTRL, 32'h1018);
      wr_reg(gair_pkg::OFF_CTRL, 32'h18);
      set_pins(p ? 13'h0004 : 13'h0000, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
